// ### timer_cc_consts.vh
`ifndef TIMER_CC_CONSTS_VH
`define TIMER_CC_CONSTS_VH

// Register index within a channel window (addr[2:0])
`define REG_IO_SELECT   3'h0
`define REG_FLAG        3'h1
`define REG_IRQ_ENABLE  3'h2
`define REG_GRA_HI      3'h3
`define REG_GRA_LO      3'h4
`define REG_GRB_HI      3'h5
`define REG_GRB_LO      3'h6

// Channel select field of the byte address (addr[5:3])
`define CHAN_LSB        3
`define CHAN_COUNT      5

// Field positions
`define B_FIELD_MSB     6
`define B_FIELD_LSB     4
`define A_FIELD_MSB     2
`define A_FIELD_LSB     0
`define IO_FIXED_BIT    3
`define FLAG_WRAP       2
`define FLAG_B          1
`define FLAG_A          0

// Function field encodings
`define FN_NONE         3'h0
`define FN_LOW          3'h1
`define FN_HIGH         3'h2
`define FN_TOGGLE       3'h3
`define FN_CAP_RISE     3'h4
`define FN_CAP_FALL     3'h5
`define FN_CAP_BOTH     3'h6

// Reset values; undefined bit 7 is taken as 0
`define IO_SELECT_RST   8'h08
`define FLAG_RST        8'h78
`define IRQ_ENABLE_RST  8'h78
`define RESERVED_ONES   4'hF
`define UNMAPPED_READ   8'h00

// Counter wrap points
`define CNT_TOP         16'hFFFF
`define CNT_BOTTOM      16'h0000

`endif

// ### pin_edge_sync.v
`timescale 1ns/1ps
module pin_edge_sync #(
    parameter W = 10
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Pins
    input  wire [W-1:0] pin_in,
    // Edge pulses
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    reg [W-1:0] last_q;
    reg [1:0]   warm_q;

    // First stage feeds only the second stage
    always @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
            last_q <= {W{1'b0}};
            warm_q <= 2'h0;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            if (warm_q != 2'h3)
            begin
                warm_q <= warm_q + 2'h1;
            end
        end
    end

    // No edges until last_q holds a real pin sample, so a pin idling
    // high gives no false edge; edges right after reset are lost
    wire        live = (warm_q == 2'h3);

    assign rise = {W{live}} & sync_q & ~last_q;
    assign fall = {W{live}} & ~sync_q & last_q;

endmodule

// ### timer_capture_compare_ctrl.v
`timescale 1ns/1ps
`include "timer_cc_consts.vh"
module timer_capture_compare_ctrl #(
    parameter CH = 5,
    parameter CW = 16
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    input  wire             standby,
    // Peripheral byte bus
    input  wire             bus_sel,
    input  wire             bus_wr,
    input  wire [5:0]       bus_addr,
    input  wire [7:0]       bus_wdata,
    output reg  [7:0]       bus_rdata,
    // Counters, one per channel
    input  wire [CH*CW-1:0] timer_counter,
    // Mode bits from the mode and function registers
    input  wire             quadrature_mode_bit,
    input  wire             combined_mode_bit1,
    input  wire             combined_mode_bit0,
    // DMA transfer started by a flag A request, channels 0-3
    input  wire [3:0]       dma_ack_a,
    // Channel pins
    input  wire [CH-1:0]    chan_pin_a_in,
    input  wire [CH-1:0]    chan_pin_b_in,
    output wire [CH-1:0]    chan_pin_a_out,
    output wire [CH-1:0]    chan_pin_a_oe,
    output wire [CH-1:0]    chan_pin_b_out,
    output wire [CH-1:0]    chan_pin_b_oe,
    // Interrupt requests
    output wire [CH-1:0]    wrap_irq,
    output wire [CH-1:0]    match_capture_irq_a,
    output wire [CH-1:0]    match_capture_irq_b
);

    // Capture-edge decode, shared by both sides of every channel
    function cap_hit;
        input [2:0] fn;
        input       rise;
        input       fall;
        begin
            case (fn)
                `FN_CAP_RISE: cap_hit = rise;
                `FN_CAP_FALL: cap_hit = fall;
                `FN_CAP_BOTH: cap_hit = rise | fall;
                default:      cap_hit = 1'b0;
            endcase
        end
    endfunction

    // Pin level after a compare match
    function pin_next;
        input [2:0] fn;
        input       cur;
        input       no_toggle;
        begin
            case (fn)
                `FN_LOW:    pin_next = 1'b0;
                `FN_HIGH:   pin_next = 1'b1;
                `FN_TOGGLE: pin_next = no_toggle ? 1'b1 : ~cur;
                default:    pin_next = cur;
            endcase
        end
    endfunction

    // Compare function that drives its pin
    function drives_pin;
        input [2:0] fn;
        begin
            drives_pin = ~fn[2] & (fn != `FN_NONE);
        end
    endfunction

    // Reset images of the writable fields
    localparam [7:0] IO_RST    = `IO_SELECT_RST;
    localparam [7:0] FLAG_INIT = `FLAG_RST;
    localparam [7:0] IEN_RST   = `IRQ_ENABLE_RST;

    wire          init = rst | standby;
    wire [2:0]    chan_idx = bus_addr[5:`CHAN_LSB];
    wire [2:0]    reg_idx = bus_addr[2:0];
    wire          rd_cycle = bus_sel & ~bus_wr;
    wire          wr_cycle = bus_sel & bus_wr;
    // Both PWM pair modes own channels 3 and 4
    wire          pwm_pair = combined_mode_bit1;
    wire          comp_pwm = combined_mode_bit1 & ~combined_mode_bit0;

    wire [CH-1:0] rise_a;
    wire [CH-1:0] fall_a;
    wire [CH-1:0] rise_b;
    wire [CH-1:0] fall_b;

    wire [CH*8-1:0]  io_flat;
    wire [CH*3-1:0]  flag_flat;
    wire [CH*3-1:0]  ien_flat;
    wire [CH*CW-1:0] gra_flat;
    wire [CH*CW-1:0] grb_flat;

    // Pins are asynchronous to clk
    pin_edge_sync #(
        .W (2*CH)
    ) u_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in ({chan_pin_b_in, chan_pin_a_in}),
        .rise   ({rise_b, rise_a}),
        .fall   ({fall_b, fall_a})
    );

    genvar i;
    generate
        for (i = 0; i < CH; i = i + 1)
        begin : g_chan
            reg  [2:0]    fn_a_q;
            reg  [2:0]    fn_b_q;
            reg  [2:0]    flag_q;
            reg  [2:0]    arm_q;
            reg  [2:0]    ien_q;
            reg  [CW-1:0] gra_q;
            reg  [CW-1:0] grb_q;
            reg  [CW-1:0] prev_q;
            reg           pin_a_q;
            reg           pin_b_q;
            reg  [2:0]    flag_d;
            reg  [2:0]    clr;
            wire [CW-1:0] cnt = timer_counter[i*CW +: CW];
            wire          sel = bus_sel & (chan_idx == i);
            wire          rd_flag = rd_cycle & sel & (reg_idx == `REG_FLAG);
            wire          wr_io = wr_cycle & sel & (reg_idx == `REG_IO_SELECT);
            wire          wr_flag = wr_cycle & sel & (reg_idx == `REG_FLAG);
            wire          wr_ien = wr_cycle & sel & (reg_idx == `REG_IRQ_ENABLE);
            wire          wr_gah = wr_cycle & sel & (reg_idx == `REG_GRA_HI);
            wire          wr_gal = wr_cycle & sel & (reg_idx == `REG_GRA_LO);
            wire          wr_gbh = wr_cycle & sel & (reg_idx == `REG_GRB_HI);
            wire          wr_gbl = wr_cycle & sel & (reg_idx == `REG_GRB_LO);
            // PWM pair modes take channels 3/4 out of this register's hands
            wire          ovr = (i >= 3) && pwm_pair;
            wire [2:0]    fn_a = ovr ? `FN_NONE : fn_a_q;
            wire [2:0]    fn_b = ovr ? `FN_NONE : fn_b_q;
            // Match counts only on a counter step, so a stopped counter
            // sitting on the compare value raises a single flag
            wire          stepped = (cnt != prev_q);
            wire          match_a = ~fn_a[2] & stepped & (cnt == gra_q);
            wire          match_b = ~fn_b[2] & stepped & (cnt == grb_q);
            wire          cap_a = cap_hit(fn_a, rise_a[i], fall_a[i]);
            wire          cap_b = cap_hit(fn_b, rise_b[i], fall_b[i]);
            wire          down_ok = (i == 2) ? quadrature_mode_bit
                                  : (i >= 3) ? comp_pwm : 1'b0;
            wire          wrap_up = (prev_q == `CNT_TOP) && (cnt == `CNT_BOTTOM);
            wire          wrap_dn = down_ok && (prev_q == `CNT_BOTTOM) && (cnt == `CNT_TOP);
            // Index kept in range for the channel without a DMA request
            wire          dma_clr = (i < 4) ? dma_ack_a[i % 4] : 1'b0;
            wire [2:0]    set_ev = {wrap_up | wrap_dn, match_b | cap_b, match_a | cap_a};

            // Flag update: set wins over every clear
            always @*
            begin
                clr = 3'h0;
                if (wr_flag)
                begin
                    clr = arm_q & ~bus_wdata[2:0];
                end
                clr[`FLAG_A] = clr[`FLAG_A] | dma_clr;
                flag_d = (flag_q & ~clr) | set_ev;
            end

            always @(posedge clk)
            begin
                if (init)
                begin
                    fn_a_q  <= IO_RST[`A_FIELD_MSB:`A_FIELD_LSB];
                    fn_b_q  <= IO_RST[`B_FIELD_MSB:`B_FIELD_LSB];
                    flag_q  <= FLAG_INIT[2:0];
                    arm_q   <= 3'h0;
                    ien_q   <= IEN_RST[2:0];
                    gra_q   <= {CW{1'b1}};
                    grb_q   <= {CW{1'b1}};
                    prev_q  <= {CW{1'b0}};
                    pin_a_q <= 1'b0;
                    pin_b_q <= 1'b0;
                end
                else
                begin
                    prev_q <= cnt;
                    flag_q <= flag_d;
                    // Armed by a read that saw the flag at 1
                    if (wr_flag)
                    begin
                        arm_q <= 3'h0;
                    end
                    else if (rd_flag)
                    begin
                        arm_q <= arm_q | flag_q;
                    end
                    if (wr_io)
                    begin
                        fn_b_q <= bus_wdata[`B_FIELD_MSB:`B_FIELD_LSB];
                        fn_a_q <= bus_wdata[`A_FIELD_MSB:`A_FIELD_LSB];
                    end
                    if (wr_ien)
                    begin
                        ien_q <= bus_wdata[2:0];
                    end
                    // Capture beats a same-cycle software write
                    if (cap_a)
                    begin
                        gra_q <= cnt;
                    end
                    else if (wr_gah)
                    begin
                        gra_q[CW-1:8] <= bus_wdata;
                    end
                    else if (wr_gal)
                    begin
                        gra_q[7:0] <= bus_wdata;
                    end
                    if (cap_b)
                    begin
                        grb_q <= cnt;
                    end
                    else if (wr_gbh)
                    begin
                        grb_q[CW-1:8] <= bus_wdata;
                    end
                    else if (wr_gbl)
                    begin
                        grb_q[7:0] <= bus_wdata;
                    end
                    if (match_a)
                    begin
                        pin_a_q <= pin_next(fn_a, pin_a_q, i == 2);
                    end
                    if (match_b)
                    begin
                        pin_b_q <= pin_next(fn_b, pin_b_q, i == 2);
                    end
                end
            end

            // Read views of the per-channel copies
            assign io_flat[i*8 +: 8] = {1'b0, fn_b_q, 1'b1, fn_a_q};
            assign flag_flat[i*3 +: 3] = flag_q;
            assign ien_flat[i*3 +: 3] = ien_q;
            assign gra_flat[i*CW +: CW] = gra_q;
            assign grb_flat[i*CW +: CW] = grb_q;

            // Pins: only compare functions with an action drive
            assign chan_pin_a_out[i] = pin_a_q;
            assign chan_pin_b_out[i] = pin_b_q;
            assign chan_pin_a_oe[i] = drives_pin(fn_a);
            assign chan_pin_b_oe[i] = drives_pin(fn_b);

            assign wrap_irq[i] = flag_q[`FLAG_WRAP] & ien_q[`FLAG_WRAP];
            assign match_capture_irq_b[i] = flag_q[`FLAG_B] & ien_q[`FLAG_B];
            assign match_capture_irq_a[i] = flag_q[`FLAG_A] & ien_q[`FLAG_A];
        end
    endgenerate

    // Registered read data, valid the cycle after the read strobe
    reg [7:0] rd_d;

    always @*
    begin
        rd_d = `UNMAPPED_READ;
        if (chan_idx < CH)
        begin
            case (reg_idx)
                `REG_IO_SELECT:  rd_d = io_flat[chan_idx*8 +: 8];
                `REG_FLAG:       rd_d = {1'b0, `RESERVED_ONES, flag_flat[chan_idx*3 +: 3]};
                `REG_IRQ_ENABLE: rd_d = {1'b0, `RESERVED_ONES, ien_flat[chan_idx*3 +: 3]};
                `REG_GRA_HI:     rd_d = gra_flat[chan_idx*CW+8 +: 8];
                `REG_GRA_LO:     rd_d = gra_flat[chan_idx*CW +: 8];
                `REG_GRB_HI:     rd_d = grb_flat[chan_idx*CW+8 +: 8];
                `REG_GRB_LO:     rd_d = grb_flat[chan_idx*CW +: 8];
                default:         rd_d = `UNMAPPED_READ;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            bus_rdata <= 8'h00;
        end
        else if (rd_cycle)
        begin
            bus_rdata <= rd_d;
        end
    end

endmodule

// ### timer_cc_checker_assertions.sv
`timescale 1ns/1ps
module timer_cc_checker #(
    parameter CH = 5,
    parameter CW = 16
) (
    // Clock and reset
    input wire             clk,
    input wire             rst,
    input wire             standby,
    // Bus
    input wire             bus_sel,
    input wire             bus_wr,
    input wire [5:0]       bus_addr,
    input wire [7:0]       bus_wdata,
    input wire [7:0]       bus_rdata,
    // Counters and DMA
    input wire [CH*CW-1:0] timer_counter,
    input wire [3:0]       dma_ack_a,
    // Pins and interrupts
    input wire [CH-1:0]    chan_pin_a_out,
    input wire [CH-1:0]    chan_pin_a_oe,
    input wire [CH-1:0]    chan_pin_b_out,
    input wire [CH-1:0]    chan_pin_b_oe,
    input wire [CH-1:0]    wrap_irq,
    input wire [CH-1:0]    match_capture_irq_a,
    input wire [CH-1:0]    match_capture_irq_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire          rd     = bus_sel && !bus_wr;
    wire          wr     = bus_sel && bus_wr && !standby;
    wire          mapped = bus_addr[5:3] < 3'h5 && bus_addr[2:0] != 3'h7;
    wire [CW-1:0] cnt0   = timer_counter[CW-1:0];

    chk_reset_quiet:
        assert property ($fell(rst) |-> !(chan_pin_a_out | chan_pin_b_out | wrap_irq
            | match_capture_irq_a | match_capture_irq_b)) else $error("outputs not quiet");
    chk_io_fixed:
        assert property (rd && mapped && bus_addr[2:0] == 3'h0
            |=> bus_rdata[7] == 1'b0 && bus_rdata[3] == 1'b1) else $error("io bits wrong");
    chk_flag_fixed:
        assert property (rd && mapped && bus_addr[2:0] == 3'h1
            |=> bus_rdata[7:3] == 5'h0F) else $error("flag bits wrong");
    chk_unmapped_zero:
        assert property (rd && !mapped |=> bus_rdata == 8'h00) else $error("unmapped read");
    chk_oe_compare:
        assert property (wr && bus_addr == 6'h00 && bus_wdata[2:0] inside {3'h1, 3'h2, 3'h3}
            |=> chan_pin_a_oe[0]) else $error("oe a0 low");
    chk_capture_no_oe:
        assert property (wr && bus_addr == 6'h08 && bus_wdata[6] |=> !chan_pin_b_oe[1])
            else $error("capture pin driven");
    chk_enable_gate:
        assert property (wr && bus_addr == 6'h02 && !bus_wdata[0] |=> !match_capture_irq_a[0])
            else $error("irq a0 not gated");
    chk_write_one:
        assert property (match_capture_irq_a[0] && wr && bus_addr == 6'h01 && bus_wdata[0]
            && !dma_ack_a[0] |=> match_capture_irq_a[0]) else $error("flag a0 lost");
    chk_pin_step:
        assert property ($changed(chan_pin_a_out[0]) && !$past(standby) && !$past(rst)
            |-> $past(cnt0) != $past(cnt0, 2) || $past(cnt0, 2) != $past(cnt0, 3))
            else $error("pin a0 moved without count");

    cover property (match_capture_irq_a[0]);
    cover property (wrap_irq[2]);
    cover property ($rose(chan_pin_a_out[2]));
endmodule

// ### host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
    // Clock
    input  wire       clk,
    // Peripheral byte bus
    output reg        bus_sel,
    output reg        bus_wr,
    output reg  [5:0] bus_addr,
    output reg  [7:0] bus_wdata,
    input  wire [7:0] bus_rdata
);
    initial
    begin
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_addr = 6'h00;
        bus_wdata = 8'h00;
    end
    task acc(input w, input [5:0] a, input [7:0] d, output [7:0] q);
    begin
        @(posedge clk);
        #1;
        bus_sel = 1'b1;
        bus_wr = w;
        bus_addr = a;
        bus_wdata = d;
        @(posedge clk);
        #1;
        q = bus_rdata;
        bus_sel = 1'b0;
        // Stale data must not look valid
        bus_wdata = ~d;
    end
    endtask
    task set_io(input [2:0] ch, input [2:0] fb, input [2:0] fa);
        reg [7:0] q;
        acc(1'b1, {ch, 3'h0}, {1'b0, fb, 1'b1, fa}, q);
    endtask
    task clear_flags(input [2:0] ch, input [2:0] m);
        reg [7:0] q;
    begin
        acc(1'b0, {ch, 3'h1}, 8'h00, q);
        acc(1'b1, {ch, 3'h1}, {5'h0F, ~m}, q);
    end
    endtask
endmodule

// ### timer_capture_compare_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin \
    err_count = err_count + 1; $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module timer_capture_compare_ctrl_test;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         standby = 1'b0;
    reg  [79:0] cnt = 80'h0;
    reg         quad = 1'b0;
    reg         cmb1 = 1'b0;
    reg         cmb0 = 1'b0;
    reg  [3:0]  dma = 4'h0;
    reg  [4:0]  pin_a = 5'h00;
    reg  [4:0]  pin_b = 5'h00;
    wire        sel, wr;
    wire [5:0]  addr;
    wire [7:0]  wd, rdat;
    wire [4:0]  pa_out, pa_oe, pb_out, pb_oe, wrap_irq, irq_a, irq_b;
    integer     err_count = 0, compares = 0, cycles = 0, k;
    reg  [2:0]  c;
    reg  [7:0]  rq;

    always #2.5 clk = ~clk;

    host_bus_model u_host_bus_model (.clk(clk), .bus_sel(sel), .bus_wr(wr), .bus_addr(addr),
        .bus_wdata(wd), .bus_rdata(rdat));
    timer_capture_compare_ctrl u_timer_capture_compare_ctrl (.clk(clk), .rst(rst),
        .standby(standby), .bus_sel(sel), .bus_wr(wr), .bus_addr(addr), .bus_wdata(wd),
        .bus_rdata(rdat), .timer_counter(cnt), .quadrature_mode_bit(quad),
        .combined_mode_bit1(cmb1), .combined_mode_bit0(cmb0), .dma_ack_a(dma),
        .chan_pin_a_in(pin_a), .chan_pin_b_in(pin_b), .chan_pin_a_out(pa_out),
        .chan_pin_a_oe(pa_oe), .chan_pin_b_out(pb_out), .chan_pin_b_oe(pb_oe), .wrap_irq(wrap_irq),
        .match_capture_irq_a(irq_a), .match_capture_irq_b(irq_b));

    task tick(input integer n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task rchk(input [5:0] a, input [7:0] e);
    begin
        u_host_bus_model.acc(1'b0, a, 8'h00, rq);
        `CHK($sformatf("reg %0h", a), e, rq)
    end
    endtask
    task wreg(input [5:0] a, input [7:0] d);
        u_host_bus_model.acc(1'b1, a, d, rq);
    endtask
    task step(input integer ch, input [15:0] v);
    begin
        @(posedge clk);
        #1;
        cnt[ch*16 +: 16] = v;
    end
    endtask
    task match(input integer ch);
    begin
        step(ch, 16'h000F);
        step(ch, 16'h0010);
        tick(3);
    end
    endtask
    task complete_run;
    begin
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 4000)
        begin
            err_count = err_count + 1;
            complete_run;
        end
    end

    initial
    begin
        tick(2);
        rst = 1'b0;
        for (c = 3'h0; c < 3'h5; c = c + 3'h1)
        begin
            rchk({c, 3'h0}, 8'h08);
            rchk({c, 3'h1}, 8'h78);
        end
        rchk(6'h2F, 8'h00);
        rchk(6'h07, 8'h00);
        $display("test reset done");
        wreg(6'h04, 8'h10);
        wreg(6'h03, 8'h00);
        wreg(6'h14, 8'h10);
        wreg(6'h13, 8'h00);
        wreg(6'h12, 8'h79);
        u_host_bus_model.set_io(3'h0, 3'h0, 3'h2);
        `CHK("pin a0 idle", 1'b0, pa_out[0])
        for (k = 0; k < 4; k = k + 1)
        begin
            u_host_bus_model.set_io(3'h0, 3'h0, k[1] ? 3'h3 : {1'b0, ~k[0], k[0]});
            match(0);
            `CHK("pin a0", ~k[0], pa_out[0])
        end
        u_host_bus_model.set_io(3'h2, 3'h3, 3'h3);
        match(2);
        match(2);
        `CHK("pin a2", 1'b1, pa_out[2])
        wreg(6'h02, 8'h79);
        wreg(6'h01, 8'h78);
        wreg(6'h01, 8'h7F);
        `CHK("irq a0", 1'b1, irq_a[0])
        u_host_bus_model.clear_flags(3'h0, 3'h1);
        `CHK("irq a0 clear", 1'b0, irq_a[0])
        rchk(6'h01, 8'h78);
        $display("test compare done");
        u_host_bus_model.set_io(3'h1, 3'h4, 3'h5);
        step(1, 16'h1234);
        pin_a = 5'h02;
        pin_b = 5'h02;
        tick(5);
        step(1, 16'h5678);
        pin_a = 5'h00;
        pin_b = 5'h00;
        tick(5);
        rchk(6'h0E, 8'h34);
        rchk(6'h0C, 8'h78);
        rchk(6'h09, 8'h7B);
        u_host_bus_model.set_io(3'h1, 3'h6, 3'h5);
        step(1, 16'h9ABC);
        pin_b = 5'h02;
        tick(5);
        rchk(6'h0E, 8'hBC);
        step(1, 16'hDEF0);
        pin_b = 5'h00;
        tick(5);
        rchk(6'h0E, 8'hF0);
        $display("test capture done");
        wreg(6'h02, 8'h7C);
        wreg(6'h0A, 8'h7E);
        wreg(6'h12, 8'h7D);
        quad = 1'b1;
        step(0, 16'hFFFF);
        step(1, 16'h0000);
        step(2, 16'h0000);
        step(0, 16'h0000);
        step(1, 16'hFFFF);
        step(2, 16'hFFFF);
        tick(3);
        `CHK("wrap irq", 5'h05, wrap_irq)
        `CHK("irq a2", 1'b1, irq_a[2])
        `CHK("irq b", 5'h02, irq_b)
        `CHK("pin b2", 1'b1, pb_out[2])
        step(0, 16'h0000);
        dma = 4'h4;
        step(0, 16'h0000);
        dma = 4'h0;
        tick(1);
        `CHK("irq a2 dma", 1'b0, irq_a[2])
        cmb1 = 1'b1;
        u_host_bus_model.set_io(3'h3, 3'h1, 3'h2);
        `CHK("oe a3 pwm", 1'b0, pa_oe[3])
        `CHK("oe b3 pwm", 1'b0, pb_oe[3])
        step(3, 16'hFFFF);
        step(4, 16'hFFFF);
        cmb0 = 1'b1;
        tick(2);
        cmb0 = 1'b0;
        `CHK("pin a3 pwm", 1'b0, pa_out[3])
        rchk(6'h19, 8'h7F);
        rchk(6'h21, 8'h7B);
        cmb1 = 1'b0;
        #1;
        `CHK("oe a3", 1'b1, pa_oe[3])
        `CHK("oe b3", 1'b1, pb_oe[3])
        step(0, 16'h0000);
        standby = 1'b1;
        step(0, 16'h0000);
        standby = 1'b0;
        rchk(6'h00, 8'h08);
        rchk(6'h01, 8'h78);
        `CHK("pin b2 standby", 1'b0, pb_out[2])
        $display("test modes done");
        complete_run;
    end
endmodule

bind timer_capture_compare_ctrl timer_cc_checker #(.CH(CH), .CW(CW)) u_timer_cc_checker (
    .clk(clk), .rst(rst), .standby(standby), .bus_sel(bus_sel), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .timer_counter(timer_counter), .dma_ack_a(dma_ack_a), .chan_pin_a_out(chan_pin_a_out),
    .chan_pin_a_oe(chan_pin_a_oe), .chan_pin_b_out(chan_pin_b_out),
    .chan_pin_b_oe(chan_pin_b_oe), .wrap_irq(wrap_irq),
    .match_capture_irq_a(match_capture_irq_a), .match_capture_irq_b(match_capture_irq_b));
